// ==== rtl/cimx_pkg.sv ====
/*
  constants, field layouts and carrier types for the codec input and mix
  control register bank; assumes a 32-bit apb master and 16-bit registers
*/
package cimx_pkg;

    // apb address width and register indexes (byte address = index * 4)
    localparam int unsigned ADDR_W          = 8;
    localparam logic [5:0]  IDX_STATUS      = 6'h00;
    localparam logic [5:0]  IDX_ADC_INPUT   = 6'h02;
    localparam logic [5:0]  IDX_DAC2_MIX    = 6'h03;
    localparam logic [5:0]  IDX_AUX1_MIX    = 6'h04;
    localparam logic [5:0]  IDX_AUX2_MIX    = 6'h05;
    localparam logic [5:0]  IDX_AUX3_MIX    = 6'h06;
    localparam logic [5:0]  IDX_CHAN_POWER  = 6'h1B;
    localparam logic [5:0]  IDX_FUNDAMENTAL = 6'h1C;

    // mix registers in order dac2, aux1, aux2, aux3
    localparam int unsigned NUM_MIX         = 4;

    // reset values and writable bit masks
    localparam logic [15:0] ADC_INPUT_RESET = 16'h0000;
    localparam logic [15:0] ADC_INPUT_MASK  = 16'h00FF;
    localparam logic [15:0] MIX_RESET       = 16'h8888;
    localparam logic [15:0] MIX_MASK        = 16'h9F9F;
    localparam logic [3:0]  CHAN_RESET      = 4'h0;
    localparam logic        PD_REQ_RESET    = 1'b1;

    // field positions
    localparam int unsigned MIX_MUTE_L      = 15;
    localparam int unsigned MIX_GAIN_L_LSB  = 8;
    localparam int unsigned MIX_MUTE_R      = 7;
    localparam int unsigned MIX_GAIN_R_LSB  = 0;
    localparam int unsigned CH_ANALOG_EN    = 0;
    localparam int unsigned CH_AMIX_EN      = 1;
    localparam int unsigned CH_DAC2_EN      = 2;
    localparam int unsigned CH_D2D_EN       = 3;
    localparam int unsigned PD_REQ_BIT      = 0;
    localparam int unsigned STAT_PD_BIT     = 14;

    // gain meaning of the codes
    localparam logic [4:0]  MIX_GAIN_0DB    = 5'h08;
    localparam int unsigned MIC_BOOST_DB    = 20;
    localparam int unsigned ADC_STEP_CDB    = 150;

    // right adc source codes
    typedef enum logic [2:0] {
        CIMX_SRC_LINE = 3'h0,
        CIMX_SRC_MIC  = 3'h1,
        CIMX_SRC_AUX1 = 3'h2,
        CIMX_SRC_AUX2 = 3'h3,
        CIMX_SRC_AUX3 = 3'h4,
        CIMX_SRC_MONO = 3'h5,
        CIMX_SRC_DAC1 = 3'h6,
        CIMX_SRC_DAC2 = 3'h7
    } cimx_adc_src_t;

    // right adc input settings, as stored in bits 7:0
    typedef struct packed {
        cimx_adc_src_t right_adc_source_sel;
        logic          right_mic_boost_en;
        logic [3:0]    right_adc_input_gain;
    } cimx_adc_in_t;

    // one mix path, both channels
    typedef struct packed {
        logic       left_mute;
        logic [4:0] left_gain;
        logic       right_mute;
        logic [4:0] right_gain;
    } cimx_mix_t;

endpackage

// ==== rtl/cimx_regs.sv ====
/*
  codec input and mix control register bank: right adc source and gain,
  dac2 and auxiliary 1..3 mix mute and gain, channel enables and the
  converter power-down request, all behind an apb slave.
  assumes one 100 MHz clock, an async active-high reset and an active-low
  power-down pin that is asynchronous to the clock.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps
// Operation
// - three-bit code selects right adc source
// - boost bit adds fixed 20 dB
// - four-bit adc gain, 1.5 dB steps
// - adc register zero, held while powered down
// - five-bit mix gains, -1.5 dB steps
// - per-channel mix mute bits 15 and 7
// - dac2, aux1, aux2 reset to 8888
// - dac2 mix held on power or enables
// - aux mixes held on power or enables
// - aux3 mix laid out like others
// - power-down flag from pin or request
module cimx_regs
    import cimx_pkg::*;
(
    // clock and reset
    input  wire logic                SYS_CLK,
    input  wire logic                RST,
    // power-down pin, asynchronous
    input  wire logic                POWER_DOWN_PIN_N,
    // apb slave
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    // settings towards the analog section
    output cimx_adc_in_t             ADC_INPUT,
    output cimx_mix_t                MIX_DAC2,
    output cimx_mix_t                MIX_AUX1,
    output cimx_mix_t                MIX_AUX2,
    output cimx_mix_t                MIX_AUX3,
    output logic                     CONVERTER_POWERED_DOWN_FLAG
);

    // whole state of the block
    typedef struct packed {
        logic [1:0]             pd_sync;
        logic                   pd_flag;
        logic [3:0]             chan;
        logic                   pd_req;
        logic [15:0]            adc;
        logic [NUM_MIX-1:0][15:0] mix;
        logic                   ready;
        logic                   err;
        logic [31:0]            rdata;
    } cimx_state_t;

    cimx_state_t st;
    cimx_state_t next_st;

    logic               apb_acc;
    logic               wr_take;
    logic               mapped;
    logic               adc_block;
    logic [NUM_MIX-1:0] mix_block;
    logic [15:0]        read_word;

    // address decode, used for every register
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction

    // register word to mix carrier
    function automatic cimx_mix_t to_mix(input logic [15:0] w);
        cimx_mix_t m;
        m.left_mute  = w[MIX_MUTE_L];
        m.left_gain  = w[MIX_GAIN_L_LSB +: 5];
        m.right_mute = w[MIX_MUTE_R];
        m.right_gain = w[MIX_GAIN_R_LSB +: 5];
        to_mix = m;
    endfunction

    // apb phases: one wait cycle, write lands when pready is seen high
    assign apb_acc = PSEL & PENABLE;
    assign wr_take = apb_acc & PWRITE & st.ready;

    assign mapped = hit(PADDR, IDX_STATUS) | hit(PADDR, IDX_ADC_INPUT)
                  | hit(PADDR, IDX_DAC2_MIX) | hit(PADDR, IDX_AUX1_MIX)
                  | hit(PADDR, IDX_AUX2_MIX) | hit(PADDR, IDX_AUX3_MIX)
                  | hit(PADDR, IDX_CHAN_POWER) | hit(PADDR, IDX_FUNDAMENTAL);

    // write-block conditions; the registered flag already covers the pin
    always_comb
    begin
        adc_block    = st.pd_flag;
        mix_block[0] = st.pd_flag | ~st.chan[CH_D2D_EN]
                     | ~st.chan[CH_DAC2_EN] | ~st.chan[CH_ANALOG_EN];
        for (int i = 1; i < NUM_MIX; i++)
        begin
            mix_block[i] = st.pd_flag | ~st.chan[CH_AMIX_EN]
                         | ~st.chan[CH_ANALOG_EN];
        end
    end

    // read multiplexer; reserved bits read zero
    always_comb
    begin
        read_word = 16'h0000;
        if (hit(PADDR, IDX_STATUS))
        begin
            read_word[STAT_PD_BIT] = st.pd_flag;
        end
        else if (hit(PADDR, IDX_ADC_INPUT))
        begin
            read_word = st.adc;
        end
        else if (hit(PADDR, IDX_CHAN_POWER))
        begin
            read_word[3:0] = st.chan;
        end
        else if (hit(PADDR, IDX_FUNDAMENTAL))
        begin
            read_word[PD_REQ_BIT] = st.pd_req;
        end
        else
        begin
            for (int i = 0; i < NUM_MIX; i++)
            begin
                if (hit(PADDR, IDX_DAC2_MIX + 6'(i)))
                begin
                    read_word = st.mix[i];
                end
            end
        end
    end

    // next state
    always_comb
    begin
        next_st = st;
        // pin synchroniser, first stage only feeds the second
        next_st.pd_sync = {st.pd_sync[0], POWER_DOWN_PIN_N};
        next_st.pd_flag = ~st.pd_sync[1] | st.pd_req;
        next_st.ready   = apb_acc & ~st.ready;
        next_st.err     = 1'b0;
        next_st.rdata   = 32'h0000_0000;
        if (apb_acc & ~st.ready)
        begin
            next_st.err   = ~mapped;
            next_st.rdata = PWRITE ? 32'h0000_0000 : {16'h0000, read_word};
        end
        if (wr_take)
        begin
            if (hit(PADDR, IDX_CHAN_POWER))
            begin
                next_st.chan = PWDATA[3:0];
            end
            if (hit(PADDR, IDX_FUNDAMENTAL))
            begin
                next_st.pd_req = PWDATA[PD_REQ_BIT];
            end
            // reserved bits are not stored, whatever the host sends
            if (hit(PADDR, IDX_ADC_INPUT) & ~adc_block)
            begin
                next_st.adc = PWDATA[15:0] & ADC_INPUT_MASK;
            end
            for (int i = 0; i < NUM_MIX; i++)
            begin
                if (hit(PADDR, IDX_DAC2_MIX + 6'(i)) & ~mix_block[i])
                begin
                    next_st.mix[i] = PWDATA[15:0] & MIX_MASK;
                end
            end
        end
        // blocked registers are forced to default, writes are dropped
        if (adc_block)
        begin
            next_st.adc = ADC_INPUT_RESET;
        end
        for (int i = 0; i < NUM_MIX; i++)
        begin
            if (mix_block[i])
            begin
                next_st.mix[i] = MIX_RESET;
            end
        end
    end

    // state register; starts powered down since the request resets set
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            st.pd_sync <= 2'h0;
            st.pd_flag <= 1'b1;
            st.chan    <= CHAN_RESET;
            st.pd_req  <= PD_REQ_RESET;
            st.adc     <= ADC_INPUT_RESET;
            st.mix     <= {NUM_MIX{MIX_RESET}};
            st.ready   <= 1'b0;
            st.err     <= 1'b0;
            st.rdata   <= 32'h0000_0000;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs are plain wiring of state bits
    assign PRDATA                      = st.rdata;
    assign PREADY                      = st.ready;
    assign PSLVERR                     = st.err;
    assign ADC_INPUT                   = cimx_adc_in_t'(st.adc[7:0]);
    assign MIX_DAC2                    = to_mix(st.mix[0]);
    assign MIX_AUX1                    = to_mix(st.mix[1]);
    assign MIX_AUX2                    = to_mix(st.mix[2]);
    assign MIX_AUX3                    = to_mix(st.mix[3]);
    assign CONVERTER_POWERED_DOWN_FLAG = st.pd_flag;

    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    property p_adc_held;
        adc_block |=> (st.adc == ADC_INPUT_RESET) && (ADC_INPUT.right_adc_input_gain == 4'h0);
    endproperty
    a_adc_held: assert property (p_adc_held)
        else $error("adc input register not held at zero");

    property p_dac2_held;
        mix_block[0] |=> MIX_DAC2.left_mute && MIX_DAC2.right_mute && (MIX_DAC2.left_gain == MIX_GAIN_0DB);
    endproperty
    a_dac2_held: assert property (p_dac2_held)
        else $error("dac2 mix not held at default");

    property p_aux_held;
        (mix_block[1] && mix_block[3]) |=> (st.mix[1] == MIX_RESET) && (st.mix[2] == MIX_RESET)
            && (st.mix[3] == MIX_RESET);
    endproperty
    a_aux_held: assert property (p_aux_held)
        else $error("aux mix not held at default");

    property p_pd_flag;
        (!st.pd_sync[1] || st.pd_req) |=> CONVERTER_POWERED_DOWN_FLAG;
    endproperty
    a_pd_flag: assert property (p_pd_flag)
        else $error("power-down flag not set");

    property p_pd_clear;
        (st.pd_sync[1] && !st.pd_req) [*2] |-> !CONVERTER_POWERED_DOWN_FLAG;
    endproperty
    a_pd_clear: assert property (p_pd_clear)
        else $error("power-down flag stuck");

    property p_aux1_write;
        (wr_take && hit(PADDR, IDX_AUX1_MIX) && !mix_block[1] && !st.pd_req && st.pd_sync[1])
            |=> (MIX_AUX1.left_gain == $past(PWDATA[12:8])) && (MIX_AUX1.right_mute == $past(PWDATA[7]));
    endproperty
    a_aux1_write: assert property (p_aux1_write)
        else $error("aux1 mix write not stored");

    property p_adc_write;
        (wr_take && hit(PADDR, IDX_ADC_INPUT) && !adc_block && !st.pd_req && st.pd_sync[1])
            |=> (ADC_INPUT.right_adc_source_sel == $past(PWDATA[7:5]))
            && (ADC_INPUT.right_mic_boost_en == $past(PWDATA[4]));
    endproperty
    a_adc_write: assert property (p_adc_write)
        else $error("adc source or boost not stored");

    property p_reserved_zero;
        ##1 ((st.mix[3] & ~MIX_MASK) == 16'h0000) && ((st.adc & ~ADC_INPUT_MASK) == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits stored");

    property p_blocked_no_err;
        (apb_acc && !st.ready && PWRITE && hit(PADDR, IDX_DAC2_MIX) && mix_block[0])
            |=> PREADY && !PSLVERR;
    endproperty
    a_blocked_no_err: assert property (p_blocked_no_err)
        else $error("blocked write answered with error");

    property p_one_wait;
        (apb_acc && !st.ready) |=> PREADY ##1 !PREADY;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("apb answer timing wrong");

    c_dac2_write: cover property (wr_take && hit(PADDR, IDX_DAC2_MIX) && !mix_block[0]);
    c_blocked_write: cover property (wr_take && hit(PADDR, IDX_AUX2_MIX) && mix_block[2]);
    c_status_read: cover property (apb_acc && !PWRITE && hit(PADDR, IDX_STATUS) && PREADY);
    c_power_up: cover property (CONVERTER_POWERED_DOWN_FLAG ##1 !CONVERTER_POWERED_DOWN_FLAG);

endmodule

// ==== verification/cimx_host.sv ====
/*
  host model: an apb master that issues one transfer at a time for the bench.
  assumes the bench calls xfer from one process only.
*/
`timescale 1ns/10ps
module cimx_host
    import cimx_pkg::*;
(
    // clock
    input  wire logic              SYS_CLK,
    // apb master side
    output logic                   PSEL,
    output logic                   PENABLE,
    output logic                   PWRITE,
    output logic [ADDR_W-1:0]      PADDR,
    output logic [31:0]            PWDATA,
    input  wire logic [31:0]       PRDATA,
    input  wire logic              PREADY,
    input  wire logic              PSLVERR
);
    // idle bus at time zero
    initial
    begin
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = '0;
        PWDATA  = '0;
    end

    // one transfer; gap idle cycles first so the host can be prompt or slow
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input int gap, output logic [31:0] rd, output logic err);
        repeat (gap) @(posedge SYS_CLK);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        // no wait count assumed: only the bench watchdog ends a hang
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        // released lines show the inverse so stale values cannot pass
        PADDR   <= ~a;
        PWDATA  <= ~d;
    endtask
endmodule

// ==== verification/test_codec_input_mix_control_regs.sv ====
/*
  self-checking bench for the input and mix control register bank.
  assumes cimx_host drives apb; expectations come from the field layout.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module test_codec_input_mix_control_regs
    import cimx_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    logic                pin_n = 1'b1;
    logic                psel, penable, pwrite, pready, pslverr, flag, er;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata, prdata, rd;
    cimx_adc_in_t        adc_o;
    cimx_mix_t           mix_o [4];
    logic [15:0]         md [4];
    logic [7:0]          ad;
    int                  err_count = 0;
    int                  total_checks = 0;

    always #5 sys_clk = ~sys_clk;

    cimx_host i_host (.SYS_CLK(sys_clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

    cimx_regs i_dut (.SYS_CLK(sys_clk), .RST(rst), .POWER_DOWN_PIN_N(pin_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ADC_INPUT(adc_o), .MIX_DAC2(mix_o[0]), .MIX_AUX1(mix_o[1]),
        .MIX_AUX2(mix_o[2]), .MIX_AUX3(mix_o[3]), .CONVERTER_POWERED_DOWN_FLAG(flag));

    // expected mix output from a stored word: mutes 15/7, gains 12:8/4:0
    function automatic cimx_mix_t exp_mix(logic [15:0] d);
        return {d[15], d[12:8], d[7], d[4:0]};
    endfunction

    task automatic acc(input logic w, input logic [5:0] idx, input logic [31:0] d);
        i_host.xfer(w, {idx, 2'b00}, d, $urandom_range(2), rd, er);
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [15:0] e);
        acc(1'b0, idx, 32'h0);
        `CHK(rd, {16'h0000, e})
    endtask

    // flag path has a synchroniser, so allow a few edges
    task automatic settle;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog: the sequence needs under a thousand cycles, this allows 20000
    initial
    begin
        #200000;
        err_count++;
        give_verdict;
    end

    initial
    begin
        void'($urandom(32'h55dc));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        settle;
        `CHK(adc_o, cimx_adc_in_t'(8'h00));
        `CHK(flag, 1'b1);
        rchk(IDX_ADC_INPUT, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            `CHK(mix_o[k], exp_mix(16'h8888));
            rchk(IDX_DAC2_MIX + 6'(k), 16'h8888);
        end
        acc(1'b1, IDX_DAC2_MIX, 32'h0000_1F1F);
        `CHK(er, 1'b0);
        rchk(IDX_DAC2_MIX, 16'h8888);
        acc(1'b1, IDX_ADC_INPUT, 32'h55);
        rchk(IDX_ADC_INPUT, 16'h0000);
        acc(1'b0, 6'h3F, 32'h0);
        `CHK(er, 1'b1);
        $display("test reset done");
        acc(1'b1, IDX_FUNDAMENTAL, 32'h0);
        acc(1'b1, IDX_CHAN_POWER, 32'hF);
        settle;
        `CHK(flag, 1'b0);
        acc(1'b0, IDX_STATUS, 32'h0);
        `CHK(rd[14], 1'b0);
        // every source code, with all-zero mix words first and all-one adc and mix words last
        for (int i = 0; i < 8; i++)
        begin
            ad = (i == 7) ? 8'hFF : {3'(i), 5'($urandom)};
            acc(1'b1, IDX_ADC_INPUT, {24'h0, ad});
            for (int k = 0; k < 4; k++)
            begin
                md[k] = (i == 0) ? 16'h0 : (i == 7) ? MIX_MASK : 16'($urandom) & MIX_MASK;
                acc(1'b1, IDX_DAC2_MIX + 6'(k), {16'h0, md[k]});
            end
            settle;
            `CHK(adc_o.right_adc_source_sel, cimx_adc_src_t'(3'(i)));
            `CHK(adc_o.right_mic_boost_en, ad[4]);
            `CHK(adc_o.right_adc_input_gain, ad[3:0]);
            rchk(IDX_ADC_INPUT, {8'h00, ad});
            for (int k = 0; k < 4; k++)
            begin
                `CHK(mix_o[k], exp_mix(md[k]));
                rchk(IDX_DAC2_MIX + 6'(k), md[k]);
            end
        end
        $display("test fields done");
        // reset in mid-run must clear settings that software has written
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(adc_o, cimx_adc_in_t'(8'h00));
        for (int k = 0; k < 4; k++)
            `CHK(mix_o[k], exp_mix(16'h8888));
        `CHK(flag, 1'b1);
        @(posedge sys_clk);
        rst <= 1'b0;
        settle;
        `CHK(flag, 1'b1);
        rchk(IDX_ADC_INPUT, 16'h0000);
        // bring the bank back up; the enables test needs aux1 holding md[1]
        acc(1'b1, IDX_FUNDAMENTAL, 32'h0);
        acc(1'b1, IDX_CHAN_POWER, 32'hF);
        acc(1'b1, IDX_AUX1_MIX, {16'h0, md[1]});
        $display("test mid-run reset done");
        acc(1'b1, IDX_CHAN_POWER, 32'h7);
        settle;
        `CHK(mix_o[0], exp_mix(16'h8888));
        `CHK(mix_o[1], exp_mix(md[1]));
        acc(1'b1, IDX_CHAN_POWER, 32'hD);
        settle;
        for (int k = 1; k < 4; k++)
            `CHK(mix_o[k], exp_mix(16'h8888));
        acc(1'b1, IDX_DAC2_MIX, 32'h0101);
        settle;
        `CHK(mix_o[0], exp_mix(16'h0101));
        // dac2 enable alone low blocks dac2 but leaves the aux mixes open
        acc(1'b1, IDX_CHAN_POWER, 32'hB);
        acc(1'b1, IDX_AUX1_MIX, 32'h1F00);
        settle;
        `CHK(mix_o[0], exp_mix(16'h8888));
        `CHK(mix_o[1], exp_mix(16'h1F00));
        acc(1'b1, IDX_CHAN_POWER, 32'hF);
        acc(1'b1, IDX_DAC2_MIX, 32'h0101);
        settle;
        `CHK(mix_o[0], exp_mix(16'h0101));
        acc(1'b1, IDX_CHAN_POWER, 32'hE);
        settle;
        `CHK(mix_o[0], exp_mix(16'h8888));
        `CHK(mix_o[1], exp_mix(16'h8888));
        $display("test enables done");
        acc(1'b1, IDX_CHAN_POWER, 32'hF);
        acc(1'b1, IDX_ADC_INPUT, 32'h3A);
        @(posedge sys_clk);
        pin_n <= 1'b0;
        settle;
        `CHK(flag, 1'b1);
        `CHK(adc_o, cimx_adc_in_t'(8'h00));
        acc(1'b1, IDX_ADC_INPUT, 32'h3A);
        `CHK(er, 1'b0);
        rchk(IDX_ADC_INPUT, 16'h0000);
        @(posedge sys_clk);
        pin_n <= 1'b1;
        settle;
        `CHK(flag, 1'b0);
        acc(1'b1, IDX_ADC_INPUT, 32'h3A);
        rchk(IDX_ADC_INPUT, 16'h003A);
        acc(1'b1, IDX_FUNDAMENTAL, 32'h1);
        settle;
        `CHK(flag, 1'b1);
        `CHK(adc_o, cimx_adc_in_t'(8'h00));
        rchk(IDX_STATUS, 16'h4000);
        $display("test power down done");
        give_verdict;
    end
endmodule
